// ### mtc_chan.sv
// One timer channel: counter, four general registers and four timer pins
`default_nettype none
module mtc_chan
  import mtc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic lock,
  input wire logic [5:0] mode,
  input wire logic [2:0] clr_src,
  input wire logic [15:0] io,
  input wire logic io_wr,
  input wire logic cnt_wr,
  input wire logic [3:0] gr_wr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] pin_in,
  input wire logic sync_in,
  output logic clr_out,
  output logic [15:0] cnt,
  output logic [3:0][15:0] gr,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [3:0][15:0] gr;
    logic [3:0] lvl;
    logic [3:0] oe_n;
    logic [3:0] prev;
  } mtc_chan_st_t;

  mtc_chan_st_t st;
  mtc_chan_st_t next_st;
  logic [3:0] ev;
  logic [3:0] cap;
  logic [3:0] buf_use;
  logic sync_clr;
  logic [1:0] step;

  function automatic logic [1:0] quad_step(input logic [3:0] t);
    unique case (t)
      4'h2, 4'hb, 4'hd, 4'h4: quad_step = 2'h1;
      4'h1, 4'h7, 4'he, 4'h8: quad_step = 2'h2;
      default: quad_step = 2'h0;
    endcase
  endfunction

  //==========================================================
  // Capture and compare events
  always_comb begin
    for (int r = 0; r < 4; r++) begin
      buf_use[r] = (r == 2 && mode[BFA_POS]) || (r == 3 && mode[BFB_POS]);
      cap[r] = io[4*r+IO_CAP_POS];
      if (cap[r]) begin
        if (io[4*r+1]) begin
          ev[r] = pin_in[r] != st.prev[r];
        end else if (io[4*r]) begin
          ev[r] = st.prev[r] && !pin_in[r];
        end else begin
          ev[r] = !st.prev[r] && pin_in[r];
        end
        ev[r] = ev[r] && !io[4*r+IO_INIT_POS];
      end else begin
        ev[r] = st.cnt == st.gr[r];
      end
      ev[r] = ev[r] && run && !buf_use[r];
    end
    unique case (clr_src)
      CLR_A: clr_out = ev[0];
      CLR_B: clr_out = ev[1];
      CLR_C: clr_out = ev[2];
      CLR_D: clr_out = ev[3];
      default: clr_out = 1'b0;
    endcase
    sync_clr = run && lock && clr_src[1:0] == CLR_SYNC_LOW && sync_in;
    step = quad_step({st.prev[1:0], pin_in[1:0]});
  end

  //==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.prev = pin_in;
    if (cnt_wr) begin
      next_st.cnt = wdata;
    end else if (clr_out || sync_clr) begin
      next_st.cnt = 16'h0000;
    end else if (run && mode[PH_POS]) begin
      if (step == 2'h1) begin
        next_st.cnt = st.cnt + 16'h0001;
      end else if (step == 2'h2) begin
        next_st.cnt = st.cnt - 16'h0001;
      end
    end else if (run) begin
      next_st.cnt = st.cnt + 16'h0001;
    end
    for (int r = 0; r < 4; r++) begin
      if (ev[r] && cap[r]) begin
        next_st.gr[r] = st.cnt;
      end else if (ev[r]) begin
        unique case (io[4*r +: 2])
          ACT_NONE: ;
          ACT_LOW: next_st.lvl[r] = 1'b0;
          ACT_HIGH: next_st.lvl[r] = 1'b1;
          ACT_TOGGLE: next_st.lvl[r] = !st.lvl[r];
        endcase
      end
      next_st.oe_n[r] = cap[r] || buf_use[r] || io[4*r +: 2] == ACT_NONE;
    end
    if (mode[BFA_POS] && ev[0]) begin
      if (cap[0]) begin
        next_st.gr[2] = st.gr[0];
      end else begin
        next_st.gr[0] = st.gr[2];
      end
    end
    if (mode[BFB_POS] && ev[1]) begin
      if (cap[1]) begin
        next_st.gr[3] = st.gr[1];
      end else begin
        next_st.gr[1] = st.gr[3];
      end
    end
    if ((clr_out || sync_clr) && (mode[2:0] == MD_PWM1 || mode[2:0] == MD_PWM2)) begin
      next_st.lvl[0] = io[IO_INIT_POS];
    end
    if (io_wr && !run) begin
      for (int r = 0; r < 4; r++) begin
        next_st.lvl[r] = io[4*r+IO_INIT_POS];
      end
    end
    for (int r = 0; r < 4; r++) begin
      if (gr_wr[r]) begin
        next_st.gr[r] = wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.oe_n <= OE_N_RST;
    end else begin
      st <= next_st;
    end
  end

  assign cnt = st.cnt;
  assign gr = st.gr;
  assign pin_out = st.lvl;
  assign pin_oe_n = st.oe_n;

  //==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_clear_third;
    clr_src == CLR_C && ev[2] && !cnt_wr |=> st.cnt == 16'h0000;
  endproperty
  a_clear_third: assert property (p_clear_third) else $error("Third register event did not clear");

  property p_clear_fourth;
    clr_src == CLR_D && run && !mode[BFB_POS] && !cap[3] && st.cnt == st.gr[3] && !cnt_wr
      |=> st.cnt == 16'h0000;
  endproperty
  a_clear_fourth: assert property (p_clear_fourth) else $error("Fourth register match did not clear");

  property p_phase_hold;
    run && mode[PH_POS] && pin_in[1:0] == st.prev[1:0] && !cnt_wr && !clr_out && !sync_clr
      |=> $stable(st.cnt);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("Phase mode counted without pin edge");

  property p_buf_a;
    mode[BFA_POS] && ev[0] && !cap[0] && !gr_wr[0] |=> st.gr[0] == $past(st.gr[2]);
  endproperty
  a_buf_a: assert property (p_buf_a) else $error("First register not loaded from buffer");

  property p_buf_b;
    mode[BFB_POS] && ev[1] && cap[1] && !gr_wr[3] |=> st.gr[3] == $past(st.gr[1]);
  endproperty
  a_buf_b: assert property (p_buf_b) else $error("Capture not moved into fourth register");

  property p_buf_quiet;
    mode[BFA_POS] && !gr_wr[2] && !(ev[0] && cap[0]) |=> $stable(st.gr[2]);
  endproperty
  a_buf_quiet: assert property (p_buf_quiet) else $error("Buffer register changed by own event");
endmodule
`default_nettype wire

// ### mtc_pin_model.sv
// Far-side model of the twelve timer pins
`default_nettype none
module mtc_pin_model (
  input wire logic clk,
  input wire logic [11:0] pin_out,
  input wire logic [11:0] pin_oe_n,
  output logic [11:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  //==========================================================
  // Undriven pins carry a pattern that changes every cycle
  logic [11:0] float_pat = 12'h5a5;
  always @(posedge clk) begin
    float_pat <= ~float_pat;
  end
  // Pins driven by the block read back their own level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & float_pat);
endmodule
`default_nettype wire

// ### mtc_pkg.sv
// Constants shared by the three-channel timer control block
//==========================================================
`default_nettype none
package mtc_pkg;
  //==========================================================
  // Bus and register map, indices of 32-bit words
  localparam int NCH = 3;
  localparam int AW = 18;
  localparam logic [15:0] RUN_IDX = 16'hffc0;
  localparam logic [15:0] LOCK_IDX = 16'hffc1;
  localparam logic [15:0] MODE0_IDX = 16'hffd1;
  localparam logic [2:0] CTRL_OFS = 3'h0;
  localparam logic [2:0] MODE_OFS = 3'h1;
  localparam logic [2:0] IO_OFS = 3'h2;
  localparam logic [2:0] CNT_OFS = 3'h3;
  localparam logic [15:0] CH_BASE_IDX = MODE0_IDX - {13'h0000, MODE_OFS};
  localparam logic [15:0] CH_SPAN = 16'h0018;
  //==========================================================
  // Values after reset
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] LOCK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'hc0;
  localparam logic [2:0] CLR_RST = 3'h0;
  localparam logic [15:0] IO_RST = 16'h0000;
  localparam logic [3:0] OE_N_RST = 4'hf;
  //==========================================================
  // Field positions and encodings
  localparam int BFA_POS = 4;
  localparam int BFB_POS = 5;
  localparam int PH_POS = 2;
  localparam int IO_CAP_POS = 3;
  localparam int IO_INIT_POS = 2;
  localparam logic [2:0] MD_PWM1 = 3'h2;
  localparam logic [2:0] MD_PWM2 = 3'h3;
  localparam logic [2:0] CLR_A = 3'h1;
  localparam logic [2:0] CLR_B = 3'h2;
  localparam logic [2:0] CLR_C = 3'h5;
  localparam logic [2:0] CLR_D = 3'h6;
  localparam logic [1:0] CLR_SYNC_LOW = 2'h3;
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
endpackage
`default_nettype wire

// ### mtc_top.sv
// Three-channel timer control with APB register access and pin synchronisers
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module mtc_top
  import mtc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [4*NCH-1:0] TIMER_PIN_IN,
  output logic [4*NCH-1:0] TIMER_PIN_OUT,
  output logic [4*NCH-1:0] TIMER_PIN_OE_N
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [NCH-1:0] run;
    logic [NCH-1:0] lock;
    logic [NCH-1:0][2:0] clr;
    logic [NCH-1:0][5:0] mode;
    logic [NCH-1:0][15:0] io;
    logic [NCH-1:0] io_wr_d;
    logic [4*NCH-1:0] s1;
    logic [4*NCH-1:0] s2;
    logic [4*NCH-1:0] s3;
    logic [4*NCH-1:0] lv;
  } mtc_top_st_t;

  mtc_top_st_t st;
  mtc_top_st_t next_st;

  logic [15:0] idx;
  logic [15:0] rel;
  logic ch_hit;
  logic [1:0] ch_sel;
  logic [2:0] ofs;
  logic hit;
  logic wr_take;
  logic [31:0] rd_val;
  logic [NCH-1:0] bus_cnt_wr;
  logic [NCH-1:0] cnt_wr;
  logic [NCH-1:0][3:0] gr_wr;
  logic preset;
  logic [NCH-1:0] ch_clr;
  logic [NCH-1:0] sync_src;
  logic [NCH-1:0] sync_in;
  logic [NCH-1:0][15:0] ch_cnt;
  logic [NCH-1:0][3:0][15:0] ch_gr;

  //==========================================================
  // Address decode
  always_comb begin
    idx = PADDR[AW-1:2];
    rel = idx - CH_BASE_IDX;
    ch_hit = idx >= CH_BASE_IDX && rel < CH_SPAN;
    ch_sel = rel[4:3];
    ofs = rel[2:0];
    hit = idx == RUN_IDX || idx == LOCK_IDX || ch_hit;
    wr_take = PSEL && PENABLE && st.pready && PWRITE && hit;
  end

  //==========================================================
  // Read data
  always_comb begin
    rd_val = 32'h0000_0000;
    if (idx == RUN_IDX) begin
      rd_val = {29'h0000_0000, st.run};
    end else if (idx == LOCK_IDX) begin
      rd_val = {29'h0000_0000, st.lock};
    end else if (ch_hit) begin
      unique case (ofs)
        CTRL_OFS: rd_val = {29'h0000_0000, st.clr[ch_sel]};
        MODE_OFS: rd_val = {24'h00_0000, MODE_RST[7:6], st.mode[ch_sel]};
        IO_OFS: rd_val = {16'h0000, st.io[ch_sel]};
        CNT_OFS: rd_val = {16'h0000, ch_cnt[ch_sel]};
        default: rd_val = {16'h0000, ch_gr[ch_sel][ofs[1:0]]};
      endcase
    end
  end

  //==========================================================
  // Counter and general register write strobes
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      bus_cnt_wr[n] = wr_take && ch_hit && ch_sel == 2'(n) && ofs == CNT_OFS;
      for (int r = 0; r < 4; r++) begin
        gr_wr[n][r] = wr_take && ch_hit && ch_sel == 2'(n) && ofs[2] && ofs[1:0] == 2'(r);
      end
    end
    preset = |(bus_cnt_wr & st.lock);
    for (int n = 0; n < NCH; n++) begin
      cnt_wr[n] = bus_cnt_wr[n] || (st.lock[n] && preset);
    end
    sync_src = ch_clr & st.lock;
  end

  //==========================================================
  // Register state and pin synchronisers
  always_comb begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.io_wr_d = '0;
    if (PSEL && PENABLE && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata = PWRITE ? 32'h0000_0000 : rd_val;
    end
    if (wr_take) begin
      if (idx == RUN_IDX) begin
        next_st.run = PWDATA[NCH-1:0];
      end else if (idx == LOCK_IDX) begin
        next_st.lock = PWDATA[NCH-1:0];
      end else begin
        unique case (ofs)
          CTRL_OFS: next_st.clr[ch_sel] = PWDATA[2:0];
          MODE_OFS: next_st.mode[ch_sel] = PWDATA[5:0];
          IO_OFS: begin
            next_st.io[ch_sel] = PWDATA[15:0];
            next_st.io_wr_d[ch_sel] = 1'b1;
          end
          default: ;
        endcase
      end
    end
    next_st.s1 = TIMER_PIN_IN;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lv = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.lv);
  end

  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      st <= '0;
      st.run <= RUN_RST[NCH-1:0];
      st.lock <= LOCK_RST[NCH-1:0];
      st.clr <= {NCH{CLR_RST}};
      st.mode <= {NCH{MODE_RST[5:0]}};
      st.io <= {NCH{IO_RST}};
    end else begin
      st <= next_st;
    end
  end

  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign PRDATA = st.prdata;

  //==========================================================
  // Channels
  genvar n;
  generate
    for (n = 0; n < NCH; n++) begin : g_ch
      assign sync_in[n] = |(sync_src & ~(3'b001 << n));
      mtc_chan i_mtc_chan (
        .clk(REF_CLK),
        .nrst(NRST),
        .run(st.run[n]),
        .lock(st.lock[n]),
        .mode(st.mode[n]),
        .clr_src(st.clr[n]),
        .io(st.io[n]),
        .io_wr(st.io_wr_d[n]),
        .cnt_wr(cnt_wr[n]),
        .gr_wr(gr_wr[n]),
        .wdata(PWDATA[15:0]),
        .pin_in(st.lv[4*n +: 4]),
        .sync_in(sync_in[n]),
        .clr_out(ch_clr[n]),
        .cnt(ch_cnt[n]),
        .gr(ch_gr[n]),
        .pin_out(TIMER_PIN_OUT[4*n +: 4]),
        .pin_oe_n(TIMER_PIN_OE_N[4*n +: 4])
      );
    end
  endgenerate

  //==========================================================
  // Checks
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  property p_run_hold;
    !st.run[0] && !cnt_wr[0] |=> ch_cnt[0] == $past(ch_cnt[0]);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("Stopped counter changed");

  property p_run_count;
    st.run[2] && st.mode[2][2:0] == 3'h0 && !cnt_wr[2] && !ch_clr[2] && !sync_in[2]
      |=> ch_cnt[2] == $past(ch_cnt[2]) + 16'h0001;
  endproperty
  a_run_count: assert property (p_run_count) else $error("Running counter did not step");

  property p_stop_level;
    !st.run[0] && !st.io_wr_d[0] |=> $stable(TIMER_PIN_OUT[3:0]);
  endproperty
  a_stop_level: assert property (p_stop_level) else $error("Pin level moved while stopped");

  property p_io_init;
    st.io_wr_d[1] && !st.run[1] |=> TIMER_PIN_OUT[4] == $past(st.io[1][IO_INIT_POS]);
  endproperty
  a_io_init: assert property (p_io_init) else $error("Pin not set to initial level");

  property p_sync_clear;
    st.lock[0] && st.lock[1] && st.run[1] && st.clr[1][1:0] == CLR_SYNC_LOW && ch_clr[0] && !cnt_wr[1]
      |=> ch_cnt[1] == 16'h0000;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("Partner clear not followed");

  property p_independent;
    !st.lock[1] && !st.run[1] && !bus_cnt_wr[1] |=> ch_cnt[1] == $past(ch_cnt[1]);
  endproperty
  a_independent: assert property (p_independent) else $error("Unlocked channel disturbed");

  property p_reset_state;
    @(posedge REF_CLK) disable iff (1'b0)
      !NRST |=> st.run == '0 && st.lock == '0 && st.mode == '0 && st.clr == '0 && !PREADY;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("Control not cleared by reset");
endmodule
`default_nettype wire

// ### multi_channel_timer_control_bench.sv
// Self-checking bench for the three-channel timer control
`default_nettype none
module multi_channel_timer_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import mtc_pkg::*;
  logic REF_CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [AW-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [4*NCH-1:0] TIMER_PIN_IN;
  logic [4*NCH-1:0] TIMER_PIN_OUT;
  logic [4*NCH-1:0] TIMER_PIN_OE_N;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] rnd = 8'h59;
  logic [31:0] v;
  logic [31:0] w;
  logic e;
  logic p;
  //==========================================================
  // Clock, design and pin model
  always #2 REF_CLK = ~REF_CLK;
  mtc_top i_mtc_top (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TIMER_PIN_IN(TIMER_PIN_IN), .TIMER_PIN_OUT(TIMER_PIN_OUT), .TIMER_PIN_OE_N(TIMER_PIN_OE_N));
  mtc_pin_model i_mtc_pin_model (.clk(REF_CLK), .pin_out(TIMER_PIN_OUT), .pin_oe_n(TIMER_PIN_OE_N),
    .pin_in(TIMER_PIN_IN));
  //==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] ci(int n, int o);
    return CH_BASE_IDX + 16'(8 * n + o);
  endfunction
  task automatic print_verdict();
    $display("Errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t pin got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    n = 0;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    err = PSLVERR;
    if (n >= 20) begin
      num_errors++;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic x;
    apb(1'b1, idx, d, r, x);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    logic x;
    apb(1'b0, idx, 32'h0, d, x);
  endtask
  //==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge REF_CLK);
    num_errors++;
    print_verdict();
  end
  //==========================================================
  // Scenarios
  initial begin
    repeat (8) @(posedge REF_CLK);
    NRST <= 1'b1;
    rd(RUN_IDX, v); chk_reg(v, 32'h0);
    rd(LOCK_IDX, v); chk_reg(v, 32'h0);
    for (int n = 0; n < NCH; n++) begin
      rd(ci(n, MODE_OFS), v); chk_reg(v, 32'hc0);
      rd(ci(n, CTRL_OFS), v); chk_reg(v, 32'h0);
    end
    chk_reg({20'h0, TIMER_PIN_OE_N}, 32'hfff);
    apb(1'b0, 16'h0100, 32'h0, v, e);
    chk_reg({31'h0, e}, 32'h1);
    chk_reg(v, 32'h0);
    // Mode codes on channel 1, mode bit 3 kept 0
    for (int m = 0; m < 8; m++) begin
      rnd = lfsr(rnd);
      w = {26'h0, rnd[1:0], 1'b0, 3'(m)};
      wr(ci(1, MODE_OFS), w);
      rd(ci(1, MODE_OFS), v); chk_reg(v, w | 32'hc0);
    end
    // Phase counting with floating pins that never settle keeps the count
    wr(ci(1, MODE_OFS), 32'h4);
    wr(ci(1, CNT_OFS), 32'h33);
    wr(RUN_IDX, 32'h2);
    repeat (10) @(posedge REF_CLK);
    rd(ci(1, CNT_OFS), v); chk_reg(v, 32'h33);
    wr(RUN_IDX, 32'h0);
    wr(ci(1, MODE_OFS), 32'h0);
    // Run bit holds and releases the counter
    rnd = lfsr(rnd);
    wr(ci(0, CNT_OFS), {24'h0, rnd});
    rd(ci(0, CNT_OFS), v);
    rd(ci(0, CNT_OFS), w); chk_reg(w, v);
    chk_reg(v, {24'h0, rnd});
    wr(RUN_IDX, 32'h1);
    rd(ci(0, CNT_OFS), v);
    rd(ci(0, CNT_OFS), w); chk_reg({31'h0, w > v}, 32'h1);
    // Initial pin level on a stopped channel
    wr(ci(1, IO_OFS), 32'h5);
    repeat (3) @(posedge REF_CLK);
    chk_pin(TIMER_PIN_OUT[4], 1'b1);
    chk_pin(TIMER_PIN_OE_N[4], 1'b0);
    wr(ci(1, IO_OFS), 32'h1);
    repeat (3) @(posedge REF_CLK);
    chk_pin(TIMER_PIN_OUT[4], 1'b0);
    // Toggling pin keeps its level once stopped
    wr(ci(1, IO_OFS), 32'h3);
    wr(ci(1, 4), 32'h4);
    wr(ci(1, CTRL_OFS), {29'h0, CLR_A});
    wr(ci(1, CNT_OFS), 32'h0);
    wr(RUN_IDX, 32'h3);
    rnd = lfsr(rnd);
    repeat (rnd[3:0] + 5) @(posedge REF_CLK);
    wr(RUN_IDX, 32'h1);
    @(posedge REF_CLK);
    p = TIMER_PIN_OUT[4];
    repeat (20) @(posedge REF_CLK);
    chk_pin(TIMER_PIN_OUT[4], p);
    // Clearing on third and fourth general register
    wr(ci(2, 6), 32'h6);
    wr(ci(2, 7), 32'h9);
    for (int k = 0; k < 2; k++) begin
      wr(ci(2, CTRL_OFS), {29'h0, k == 0 ? CLR_C : CLR_D});
      wr(ci(2, CNT_OFS), 32'h0);
      wr(RUN_IDX, 32'h5);
      for (int j = 0; j < 4; j++) begin
        rd(ci(2, CNT_OFS), v);
        if (k == 0) chk_reg({31'h0, v <= 6}, 32'h1);
        else chk_reg({31'h0, v <= 9}, 32'h1);
      end
    end
    // Synchronous clearing with one independent channel
    wr(RUN_IDX, 32'h0);
    wr(ci(0, 4), 32'ha);
    wr(ci(0, CTRL_OFS), {29'h0, CLR_A});
    wr(ci(1, CTRL_OFS), 32'h3);
    wr(ci(2, CTRL_OFS), 32'h0);
    wr(LOCK_IDX, 32'h3);
    for (int n = 0; n < NCH; n++) wr(ci(n, CNT_OFS), 32'h0);
    wr(RUN_IDX, 32'h7);
    for (int j = 0; j < 5; j++) begin
      rd(ci(1, CNT_OFS), v); chk_reg({31'h0, v <= 10}, 32'h1);
    end
    rd(ci(2, CNT_OFS), v); chk_reg({31'h0, v > 10}, 32'h1);
    // Buffer pairing on channel 2
    wr(RUN_IDX, 32'h0);
    wr(LOCK_IDX, 32'h0);
    wr(ci(2, MODE_OFS), 32'h30);
    wr(ci(2, IO_OFS), 32'h1111);
    wr(ci(2, 4), 32'h3);
    wr(ci(2, 5), 32'h4);
    wr(ci(2, 6), 32'h7);
    wr(ci(2, 7), 32'h8);
    for (int k = 0; k < 2; k++) begin
      wr(ci(2, CTRL_OFS), {29'h0, k == 0 ? CLR_C : CLR_D});
      wr(ci(2, CNT_OFS), 32'h0);
      wr(RUN_IDX, 32'h4);
      repeat (40) @(posedge REF_CLK);
      rd(ci(2, CNT_OFS), v); chk_reg({31'h0, v > 8}, 32'h1);
    end
    rd(ci(2, 4), v); chk_reg(v, 32'h7);
    rd(ci(2, 5), v); chk_reg(v, 32'h8);
    print_verdict();
  end
endmodule
`default_nettype wire
